// ---- touch_scan_pkg.sv ----
// constants, state and code types for the touch scan sequencer
// assumes a 40 MHz system clock; the panel oscillator is modelled
// as a half-cycle enable derived from that clock
package touch_scan_pkg;

	// ----------------------------------------------------------
	// clock rates
	// ----------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int OSC_HZ = 4_000_000;
	localparam int HALF_DIV = CLK_HZ / (2 * OSC_HZ);
	localparam int DIV_W = 8;

	// ----------------------------------------------------------
	// overheads, in oscillator half cycles or whole cycles
	// ----------------------------------------------------------
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] START_RED_HALF = 16'h0005;
	localparam logic [CNT_W-1:0] START_FULL_HALF = 16'h0007;
	localparam logic [CNT_W-1:0] STAGE_OVH_CYC = 16'h000a;
	localparam logic [CNT_W-1:0] CONV_OVH_CYC = 16'h0003;
	localparam logic [CNT_W-1:0] CONV_EXTRA_CLK = 16'h0002;
	localparam logic [CNT_W-1:0] RES_HI_BITS = 16'h000c;
	localparam logic [CNT_W-1:0] RES_LO_BITS = 16'h000a;

	// ----------------------------------------------------------
	// filter processing delays, high / low resolution
	// ----------------------------------------------------------
	localparam logic [5:0] FILTER_PROCESSING_DELAY_NONE = 6'h02;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M37_HI = 6'h1c;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M37_LO = 6'h18;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M7W3_HI = 6'h1f;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M7W3_LO = 6'h1b;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M15_HI = 6'h1f;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M15_LO = 6'h1d;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M15W3_HI = 6'h22;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M15W3_LO = 6'h20;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M15W7_HI = 6'h26;
	localparam logic [5:0] FILTER_PROCESSING_DELAY_M15W7_LO = 6'h24;

	// ----------------------------------------------------------
	// command codes, modes, measurement slots
	// ----------------------------------------------------------
	localparam logic [3:0] FUNC_FULL = 4'h0;
	localparam logic [3:0] FUNC_REDUCED = 4'h1;
	localparam logic [1:0] MODE_SELF = 2'h1;
	localparam logic [1:0] MODE_HOST = 2'h2;
	localparam int DATA_W = 12;
	localparam logic [2:0] NMEAS_FULL = 3'h7;
	localparam logic [2:0] NMEAS_RED = 3'h1;

	typedef enum logic [2:0] {
		M_X1 = 3'h0, M_X2 = 3'h1, M_IX = 3'h2, M_Y1 = 3'h3,
		M_Y2 = 3'h4, M_IY = 3'h5, M_Z1 = 3'h6, M_Z2 = 3'h7
	} meas_t;

	typedef enum logic [1:0] {
		DRV_NONE = 2'h0, DRV_Y = 2'h1, DRV_X = 2'h2, DRV_Z = 2'h3
	} drive_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_START = 3'b001, S_PRE = 3'b011,
		S_SNS = 3'b010, S_SETTLE = 3'b110, S_CONV = 3'b111,
		S_PROC = 3'b101, S_LOAD = 3'b100
	} state_t;

endpackage : touch_scan_pkg

// ---- touch_scan_sequencer.sv ----
// touch scan sequencer: pen or host started panel scans
// assumes an external converter and filter; timing runs on a
// half-cycle enable of the internal oscillator
`timescale 1ns/1ps

module touch_scan_sequencer
	import touch_scan_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic pen_start_mode_bit,
	input wire logic [1:0] touch_scan_mode_select,
	input wire logic pen_interrupt_config,
	input wire logic scan_cmd_valid,
	input wire logic [3:0] scan_cmd_code,
	input wire logic res_12bit,
	input wire logic [1:0] median_sel,
	input wire logic [1:0] window_sel,
	input wire logic [7:0] panel_settle_time,
	input wire logic [7:0] precharge_time,
	input wire logic [7:0] touch_sense_time,
	input wire logic [3:0] adc_clk_ratio,
	input wire logic touch_sense_n,
	input wire logic [DATA_W-1:0] filter_result,
	output logic touch_data_avail_out,
	output logic pen_touch,
	output logic osc_run,
	output logic ym_gnd,
	output logic xp_pullup_en,
	output logic precharge_en,
	output logic [1:0] drive_sel,
	output logic adc_power,
	output logic sample_take,
	output logic [2:0] meas_sel,
	output logic data_ready,
	output logic busy,
	output logic [DATA_W-1:0] x1_out,
	output logic [DATA_W-1:0] x2_out,
	output logic [DATA_W-1:0] x_current_coord,
	output logic [DATA_W-1:0] y1_out,
	output logic [DATA_W-1:0] y2_out,
	output logic [DATA_W-1:0] y_current_coord,
	output logic [DATA_W-1:0] pressure_first,
	output logic [DATA_W-1:0] pressure_second
);

	// ----------------------------------------------------------
	// declarations
	// ----------------------------------------------------------
	state_t state_q, state_d;
	logic [DIV_W-1:0] div_q;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [4:0] conv_cnt_q;
	logic [2:0] idx_q;
	logic full_q;
	logic [3:0] code_q;
	logic code_ok_q;
	logic [2:0] sync_q;
	logic pen_touch_q;
	logic avail_q;
	logic dav_q;
	logic ready_q;
	logic take_q;
	logic [DATA_W-1:0] tmp_q [8];
	logic [DATA_W-1:0] vis_q [8];

	// ----------------------------------------------------------
	// oscillator half-cycle enable
	// ----------------------------------------------------------
	wire half_tick = osc_run && (div_q == DIV_W'(HALF_DIV - 1));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			div_q <= '0;
		else if (!osc_run || half_tick)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	// ----------------------------------------------------------
	// touch pin synchroniser and pen touch
	// ----------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_q <= 3'h7;
			pen_touch_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[1:0], touch_sense_n};
			if (xp_pullup_en && (sync_q[1] == sync_q[2]))
				pen_touch_q <= ~sync_q[2];
		end
	end
	assign pen_touch = pen_touch_q;

	// ----------------------------------------------------------
	// filter sizing
	// ----------------------------------------------------------
	wire m_one = (median_sel == 2'h0);
	wire w_3 = (window_sel == 2'h1);
	wire w_7 = (window_sel == 2'h2);
	// invalid combinations fall back to median only
	wire m7w3 = (median_sel == 2'h2) && w_3;
	wire m15w3 = (median_sel == 2'h3) && w_3;
	wire m15w7 = (median_sel == 2'h3) && w_7;
	wire [4:0] n_avg = (window_sel == 2'h0) ? 5'h01 :
		(window_sel == 2'h1) ? 5'h04 :
		(window_sel == 2'h2) ? 5'h08 : 5'h10;
	wire [4:0] n_med = (median_sel == 2'h1) ? 5'h03 :
		(median_sel == 2'h2) ? 5'h07 : 5'h0f;
	wire [4:0] n_conv = m_one ? n_avg : n_med;
	wire [5:0] filter_processing_delay = m_one ? FILTER_PROCESSING_DELAY_NONE :
		m15w7 ? (res_12bit ? FILTER_PROCESSING_DELAY_M15W7_HI : FILTER_PROCESSING_DELAY_M15W7_LO) :
		m15w3 ? (res_12bit ? FILTER_PROCESSING_DELAY_M15W3_HI : FILTER_PROCESSING_DELAY_M15W3_LO) :
		(median_sel == 2'h3) ? (res_12bit ? FILTER_PROCESSING_DELAY_M15_HI : FILTER_PROCESSING_DELAY_M15_LO) :
		m7w3 ? (res_12bit ? FILTER_PROCESSING_DELAY_M7W3_HI : FILTER_PROCESSING_DELAY_M7W3_LO) :
		(res_12bit ? FILTER_PROCESSING_DELAY_M37_HI : FILTER_PROCESSING_DELAY_M37_LO);

	// ----------------------------------------------------------
	// interval lengths in half cycles
	// ----------------------------------------------------------
	wire [CNT_W-1:0] res_bits = res_12bit ? RES_HI_BITS : RES_LO_BITS;
	wire [CNT_W-1:0] conv_cyc = CNT_W'((res_bits + CONV_EXTRA_CLK) *
		{12'h000, adc_clk_ratio}) + CONV_OVH_CYC;
	wire [CNT_W-1:0] conv_half = {conv_cyc[CNT_W-2:0], 1'b0};
	wire [CNT_W-1:0] settle_half = {7'h00, panel_settle_time, 1'b0} +
		{STAGE_OVH_CYC[CNT_W-2:0], 1'b0};
	wire [CNT_W-1:0] pre_half = {7'h00, precharge_time, 1'b0};
	wire [CNT_W-1:0] sns_half = {7'h00, touch_sense_time, 1'b0};
	wire [CNT_W-1:0] filter_processing_delay_half = {9'h000, filter_processing_delay, 1'b0};
	wire cnt_done = (cnt_q == '0) ||
		(half_tick && (cnt_q == CNT_W'(1)));

	// ----------------------------------------------------------
	// scan order: y stage, x stage, then pressure stage in full scans only
	// ----------------------------------------------------------
	wire [2:0] last_idx = full_q ? NMEAS_FULL : NMEAS_RED;
	wire [2:0] cur_meas = !full_q ? (idx_q[0] ? M_IX : M_IY) :
		(idx_q == 3'h0) ? M_Y1 : (idx_q == 3'h1) ? M_Y2 :
		(idx_q == 3'h2) ? M_IY : (idx_q == 3'h3) ? M_X1 :
		(idx_q == 3'h4) ? M_X2 : (idx_q == 3'h5) ? M_IX :
		(idx_q == 3'h6) ? M_Z1 : M_Z2;
	wire stage_end = !full_q || (idx_q == 3'h2) || (idx_q == 3'h5);
	wire [1:0] stage_drv = (cur_meas >= M_Z1) ? DRV_Z :
		(cur_meas >= M_Y1) ? DRV_Y : DRV_X;
	wire last_conv = (conv_cnt_q + 5'h01) == n_conv;

	// ----------------------------------------------------------
	// start requests
	// ----------------------------------------------------------
	wire cmd_good = (scan_cmd_code == FUNC_FULL) ||
		(scan_cmd_code == FUNC_REDUCED);
	wire self_start = (touch_scan_mode_select == MODE_SELF) &&
		pen_start_mode_bit && code_ok_q && pen_touch_q;
	wire host_start = (touch_scan_mode_select == MODE_HOST) &&
		scan_cmd_valid && cmd_good;
	wire start_full = host_start ? (scan_cmd_code == FUNC_FULL) :
		(code_q == FUNC_FULL);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			code_q <= FUNC_FULL;
			code_ok_q <= 1'b0;
		end else if (scan_cmd_valid) begin
			code_q <= scan_cmd_code;
			code_ok_q <= cmd_good;
		end
	end

	// ----------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = (half_tick && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
		case (state_q)
		S_IDLE: begin
			if (self_start || host_start) begin
				state_d = S_START;
				cnt_d = start_full ? START_FULL_HALF :
					START_RED_HALF;
			end
		end
		S_START: begin
			if (cnt_done) begin
				state_d = S_PRE;
				cnt_d = pre_half;
			end
		end
		S_PRE: begin
			if (cnt_done) begin
				state_d = S_SNS;
				cnt_d = sns_half;
			end
		end
		S_SNS: begin
			if (cnt_done && !pen_touch_q)
				state_d = S_IDLE;
			else if (cnt_done) begin
				state_d = S_SETTLE;
				cnt_d = settle_half;
			end
		end
		S_SETTLE: begin
			if (cnt_done) begin
				state_d = S_CONV;
				cnt_d = conv_half;
			end
		end
		S_CONV: begin
			if (cnt_done && last_conv) begin
				state_d = S_PROC;
				cnt_d = filter_processing_delay_half;
			end else if (cnt_done)
				cnt_d = conv_half;
		end
		S_PROC: begin
			if (cnt_done && idx_q == last_idx)
				state_d = S_LOAD;
			else if (cnt_done && stage_end) begin
				state_d = S_PRE;
				cnt_d = pre_half;
			end else if (cnt_done) begin
				state_d = S_CONV;
				cnt_d = conv_half;
			end
		end
		S_LOAD: state_d = S_IDLE;
		default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= S_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			full_q <= 1'b0;
			idx_q <= '0;
			conv_cnt_q <= '0;
		end else if (state_q == S_IDLE) begin
			full_q <= start_full;
			idx_q <= '0;
			conv_cnt_q <= '0;
		end else if (state_q == S_CONV && cnt_done) begin
			conv_cnt_q <= last_conv ? 5'h00 : conv_cnt_q + 5'h01;
		end else if (state_q == S_PROC && cnt_done) begin
			idx_q <= idx_q + 3'h1;
		end
	end

	// ----------------------------------------------------------
	// temporary and visible result registers
	// ----------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmp_q <= '{default: '0};
			vis_q <= '{default: '0};
		end else begin
			if (state_q == S_PROC && cnt_done)
				tmp_q[cur_meas] <= filter_result;
			if (state_q == S_LOAD)
				vis_q <= tmp_q;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avail_q <= 1'b0;
			dav_q <= 1'b1;
			ready_q <= 1'b0;
			take_q <= 1'b0;
		end else begin
			if (state_q == S_LOAD)
				avail_q <= 1'b1;
			else if (state_q == S_START)
				avail_q <= 1'b0;
			dav_q <= pen_interrupt_config ? ~pen_touch_q : ~avail_q;
			ready_q <= (state_q == S_LOAD);
			take_q <= (state_q == S_CONV) && cnt_done;
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	wire driving = (state_q == S_SETTLE) || (state_q == S_CONV) ||
		(state_q == S_PROC);
	assign osc_run = (state_q != S_IDLE);
	assign ym_gnd = (state_q == S_IDLE) || (state_q == S_PRE) ||
		(state_q == S_SNS);
	assign xp_pullup_en = (state_q == S_IDLE) || (state_q == S_PRE) ||
		(state_q == S_SNS);
	assign precharge_en = (state_q == S_PRE);
	assign drive_sel = driving ? stage_drv : DRV_NONE;
	assign adc_power = (state_q == S_CONV);
	assign meas_sel = cur_meas;
	assign busy = osc_run;
	assign touch_data_avail_out = dav_q;
	assign data_ready = ready_q;
	assign sample_take = take_q;
	assign x1_out = vis_q[M_X1];
	assign x2_out = vis_q[M_X2];
	assign x_current_coord = vis_q[M_IX];
	assign y1_out = vis_q[M_Y1];
	assign y2_out = vis_q[M_Y2];
	assign y_current_coord = vis_q[M_IY];
	assign pressure_first = vis_q[M_Z1];
	assign pressure_second = vis_q[M_Z2];

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_idle_ground: assert property (
		state_q == S_IDLE |-> ym_gnd && xp_pullup_en && drive_sel == 2'h0)
		else $error("idle without ground and pull-up");
	a_pen_irq_low: assert property (
		pen_interrupt_config && pen_touch_q |=> !touch_data_avail_out)
		else $error("pen interrupt not low on touch");
	a_red_start_len: assert property (
		$rose(state_q == S_START) && !full_q |-> cnt_q == 16'h0005)
		else $error("reduced start overhead wrong");
	a_full_start_len: assert property (
		$rose(state_q == S_START) && full_q |-> cnt_q == 16'h0007)
		else $error("full start overhead wrong");
	a_settle_len: assert property (
		$rose(state_q == S_SETTLE) |->
		cnt_q == 2 * (panel_settle_time + 10))
		else $error("settle length wrong");
	a_conv_len: assert property (
		$rose(state_q == S_CONV) |-> cnt_q ==
		2 * ((res_12bit ? 14 : 12) * adc_clk_ratio + 3))
		else $error("conversion length wrong");
	a_conv_count: assert property (
		$rose(state_q == S_PROC) && $past(state_q) == S_CONV |->
		$past(conv_cnt_q) + 1 == n_conv)
		else $error("conversion count wrong");
	a_touch_abort: assert property (
		state_q == S_SNS && cnt_done && !pen_touch_q |=>
		state_q == S_IDLE ##1 $stable(y_current_coord))
		else $error("scan not abandoned");
	a_load_whole: assert property (
		$changed(y_current_coord) |-> $past(state_q) == S_LOAD)
		else $error("partial register update");
	a_host_wait: assert property (
		state_q == S_IDLE && touch_scan_mode_select == MODE_HOST &&
		!scan_cmd_valid |=> state_q == S_IDLE)
		else $error("host mode started unasked");
	a_y_first: assert property (
		state_q == S_SETTLE && idx_q == 3'h0 |-> drive_sel == DRV_Y)
		else $error("first stage not y");

	c_full_scan: cover property (state_q == S_LOAD && full_q);
	c_red_scan: cover property (state_q == S_LOAD && !full_q);
	c_abort: cover property (state_q == S_SNS && cnt_done && !pen_touch_q);

endmodule : touch_scan_sequencer

// ---- touch_panel_model.sv ----
// resistive panel model feeding the sense pin and the filter result
// assumes the bench sets the touch level and a tag for result values
`timescale 1ns/1ps

module touch_panel_model
	import touch_scan_pkg::*;
(
	input wire logic clk,
	input wire logic touched,
	input wire logic [3:0] tag,
	input wire logic xp_pullup_en,
	input wire logic ym_gnd,
	input wire logic [2:0] meas_sel,
	output logic touch_sense_n,
	output logic [DATA_W-1:0] filter_result
);
	// --------------------------------------------------------
	// sense pin and result
	// --------------------------------------------------------
	logic float_q = 1'b0;

	// pin floats when the pull-up is off: keep it moving
	always @(posedge clk) float_q <= ~float_q;

	// touch seen only through pull-up and grounded y minus
	assign touch_sense_n = xp_pullup_en ? ~(touched & ym_gnd) : float_q;
	assign filter_result = {tag, 1'b0, meas_sel, 4'h5};
endmodule : touch_panel_model

// ---- touch_scan_sequencer_test.sv ----
// self-checking bench for the touch scan sequencer
// assumes the panel model above; the bench plays the host
`timescale 1ns/1ps

module touch_scan_sequencer_test;
	import touch_scan_pkg::*;
	logic clk, rstn, psm_b, pic, cmd_v, res12, touched, sense_n;
	logic [1:0] mode, msel, wsel, dsel;
	logic [3:0] code, ratio, tag;
	logic [7:0] settle, prech_t, sense_t;
	logic tdo, pen, osc, ymg, pup, prech, adcp, take, dr, busy, busy_q;
	logic adcp_q;
	int pre_cyc = 0;
	logic [2:0] msl;
	logic [DATA_W-1:0] fres;
	logic [DATA_W-1:0] r [8];
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n_done = 0;
	int t_start, t_done, k;
	logic [2:0] slots [$];
	logic [1:0] drvs [$];
	localparam meas_t ORD [8] = '{M_Y1, M_Y2, M_IY, M_X1, M_X2, M_IX,
		M_Z1, M_Z2};

	touch_scan_sequencer i_touch_scan_sequencer (.clk(clk), .rstn(rstn),
		.pen_start_mode_bit(psm_b), .touch_scan_mode_select(mode),
		.pen_interrupt_config(pic), .scan_cmd_valid(cmd_v),
		.scan_cmd_code(code), .res_12bit(res12), .median_sel(msel),
		.window_sel(wsel), .panel_settle_time(settle),
		.precharge_time(prech_t), .touch_sense_time(sense_t),
		.adc_clk_ratio(ratio), .touch_sense_n(sense_n),
		.filter_result(fres), .touch_data_avail_out(tdo),
		.pen_touch(pen), .osc_run(osc), .ym_gnd(ymg),
		.xp_pullup_en(pup), .precharge_en(prech), .drive_sel(dsel),
		.adc_power(adcp), .sample_take(take), .meas_sel(msl),
		.data_ready(dr), .busy(busy), .x1_out(r[0]), .x2_out(r[1]),
		.x_current_coord(r[2]), .y1_out(r[3]), .y2_out(r[4]),
		.y_current_coord(r[5]), .pressure_first(r[6]),
		.pressure_second(r[7]));

	touch_panel_model i_touch_panel_model (.clk(clk), .touched(touched),
		.tag(tag), .xp_pullup_en(pup), .ym_gnd(ymg), .meas_sel(msl),
		.touch_sense_n(sense_n), .filter_result(fres));

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	function automatic logic [11:0] ev(input logic [3:0] t, input int s);
		return {t, 1'b0, s[2:0], 4'h5};
	endfunction : ev

	function automatic logic [1:0] drv_of(input logic [2:0] s);
		return (s >= 3'h6) ? 2'h3 : ((s >= 3'h3) ? 2'h1 : 2'h2);
	endfunction : drv_of

	// scan length in clocks, unit settle/precharge/sense and ratio
	function automatic int len(input bit full, input int b, input int n,
		input int pp);
		int h;
		h = full ? 7 : 5;
		h += (full ? 3 : 2) * (2 + 2 + 2 * (1 + 10));
		h += (full ? 8 : 2) * (n * 2 * ((b + 2) + 3) + 2 * pp);
		return 5 * h;
	endfunction : len

	task automatic send_cmd(input logic [3:0] c);
		@(posedge clk);
		cmd_v <= 1'b1;
		code <= c;
		@(posedge clk);
		cmd_v <= 1'b0;
	endtask : send_cmd

	task automatic wait_done(input int lim, input logic exp);
		int n0;
		n0 = n_done;
		for (k = 0; k < lim && n_done == n0; k++) @(posedge clk);
		check(n_done != n0, exp);
	endtask : wait_done

	task automatic wait_idle();
		for (k = 0; k < 4000 && busy !== 1'b0; k++) @(posedge clk);
		repeat (10) @(posedge clk);
		slots.delete();
		drvs.delete();
	endtask : wait_idle

	task automatic wait_take();
		for (k = 0; k < 4000 && slots.size() == 0; k++) @(posedge clk);
	endtask : wait_take

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		busy_q <= busy;
		adcp_q <= adcp;
		if (prech === 1'b1)
			pre_cyc <= pre_cyc + 1;
		if (busy === 1'b1 && busy_q !== 1'b1)
			t_start <= cyc;
		if (dr === 1'b1) begin
			t_done <= cyc;
			n_done <= n_done + 1;
		end
		if (take === 1'b1) begin
			slots.push_back(msl);
			drvs.push_back(dsel);
			check(adcp_q & osc, 1);
		end
		if (cyc == 40000) begin
			err_count++;
			complete_run();
		end
	end

	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	initial begin
		rstn = 1'b0; psm_b = 1'b0; pic = 1'b1; cmd_v = 1'b0;
		res12 = 1'b1; touched = 1'b0; mode = 2'h0; msel = 2'h0;
		wsel = 2'h0; code = 4'h0; ratio = 4'h1; tag = 4'h1;
		settle = 8'h01; prech_t = 8'h01; sense_t = 8'h01;
		repeat (10) @(posedge clk);
		check({ymg, pup, tdo, busy, r[2]}, {4'b1110, 12'h000});
		rstn <= 1'b1;
		// self started reduced scan, host programs first
		send_cmd(FUNC_REDUCED);
		mode <= MODE_SELF;
		psm_b <= 1'b1;
		touched <= 1'b1;
		repeat (6) @(posedge clk);
		check({pen, tdo}, 2'b10);
		wait_done(2000, 1);
		touched <= 1'b0;
		k = t_done - t_start;
		check(k >= len(0, 12, 1, 2) - 5 && k <= len(0, 12, 1, 2) + 40, 1);
		check(slots.size(), 2);
		check(pre_cyc, 20);
		check({slots[0], slots[1]}, {M_IY, M_IX});
		check({drvs[0], drvs[1]}, {DRV_Y, DRV_X});
		check(r[M_IY], ev(1, M_IY));
		check(r[M_IX], ev(1, M_IX));
		wait_idle();
		// full scan with touch lifted during the y stage
		send_cmd(FUNC_FULL);
		tag <= 4'h2;
		touched <= 1'b1;
		wait_take();
		touched <= 1'b0;
		wait_done(3000, 0);
		check(busy, 0);
		check(r[M_IY], ev(1, M_IY));
		wait_idle();
		// host started full scan, 10 bit, median of three
		mode <= MODE_HOST;
		psm_b <= 1'b0;
		pic <= 1'b0;
		res12 <= 1'b0;
		msel <= 2'h1;
		tag <= 4'h3;
		touched <= 1'b1;
		repeat (60) @(posedge clk);
		check(busy, 0);
		send_cmd(4'h2);
		repeat (20) @(posedge clk);
		check(busy, 0);
		send_cmd(FUNC_FULL);
		wait_take();
		send_cmd(FUNC_FULL);
		check(r[M_IX], ev(1, M_IX));
		wait_done(8000, 1);
		@(posedge clk);
		#1;
		check(tdo, 0);
		touched <= 1'b0;
		k = t_done - t_start;
		check(k >= len(1, 10, 3, 24) - 5 && k <= len(1, 10, 3, 24) + 40, 1);
		check(slots.size(), 24);
		for (int i = 0; i < 24 && i < slots.size(); i++) begin
			check(slots[i], ORD[i / 3]);
			check(drvs[i], drv_of(ORD[i / 3]));
		end
		for (int s = 0; s < 8; s++)
			check(r[s], ev(3, s));
		complete_run();
	end
endmodule : touch_scan_sequencer_test
